// File: src/ddc_defines.vh
// Constants for the DDR SDRAM command core
`ifndef DDC_DEFINES_VH
`define DDC_DEFINES_VH

// Command codes {chip select, row strobe, column strobe, write strobe}
`define DDC_CMD_MODE_LOAD   4'h0
`define DDC_CMD_REFRESH     4'h1
`define DDC_CMD_ROW_CLOSE   4'h2
`define DDC_CMD_ROW_OPEN    4'h3
`define DDC_CMD_WRITE       4'h4
`define DDC_CMD_READ        4'h5
`define DDC_CMD_BURST_STOP  4'h6
`define DDC_CMD_NOP         4'h7

// Address, bank select and mode register fields
`define DDC_AP_BIT          10
`define DDC_BL_MSB          2
`define DDC_BL_LSB          0
`define DDC_BT_BIT          3
`define DDC_CL_MSB          6
`define DDC_CL_LSB          4
`define DDC_EXT_SEL_BIT     0

// Burst length codes and lengths
`define DDC_BL_CODE_2       3'h1
`define DDC_BL_CODE_4       3'h2
`define DDC_BL_CODE_8       3'h3
`define DDC_BL_2            4'h2
`define DDC_BL_4            4'h4
`define DDC_BL_8            4'h8

// Read latency codes and clock counts
`define DDC_CL_CODE_3       3'h3
`define DDC_CL_CODE_4       3'h4
`define DDC_CL_3            3'h3
`define DDC_CL_4            3'h4

// Reset values
`define DDC_MODE_RESET      12'h000
`define DDC_EXT_MODE_RESET  12'h000

`endif

// File: src/ddc_pair_buffer.v
// Two-entry buffer with registered outputs and valid/ready on both sides
`timescale 1ns/1ps

module ddc_pair_buffer #(
    parameter WIDTH = 41
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             inValid,
    output reg              inReady,
    input  wire [WIDTH-1:0] inData,
    output reg              outValid,
    input  wire             outReady,
    output reg  [WIDTH-1:0] outData
);

    reg [WIDTH-1:0] spareData;
    reg             spareValid;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            outValid   <= 1'b0;
            outData    <= {WIDTH{1'b0}};
            spareData  <= {WIDTH{1'b0}};
            spareValid <= 1'b0;
            inReady    <= 1'b1;
        end else begin
            if (outReady || !outValid) begin
                if (spareValid) begin
                    outData    <= spareData;
                    outValid   <= 1'b1;
                    spareValid <= 1'b0;
                    inReady    <= 1'b1;
                end else begin
                    outValid <= inValid;
                    outData  <= inData;
                end
            end else if (inValid && inReady) begin
                // Output stalled: park the word in the second entry
                spareData  <= inData;
                spareValid <= 1'b1;
                inReady    <= 1'b0;
            end
        end
    end

endmodule // ddc_pair_buffer

// File: src/ddc_command_core.v
// Command decoder, bank state and burst engine of a four-bank DDR SDRAM
`timescale 1ns/1ps
`include "ddc_defines.vh"

module ddc_command_core #(
    parameter ROW_W  = 12,
    parameter COL_W  = 9,
    parameter DATA_W = 16
) (
    input  wire                     sys_clk,
    input  wire                     reset_n,
    input  wire                     memClk,
    input  wire                     clkEnable,
    input  wire                     chipSelect_n,
    input  wire                     rowStrobe_n,
    input  wire                     colStrobe_n,
    input  wire                     writeStrobe_n,
    input  wire [1:0]               bank_select_bits,
    input  wire [ROW_W-1:0]         address,
    input  wire                     low_byte_mask,
    input  wire                     high_byte_mask,
    input  wire [DATA_W-1:0]        data_lines_in,
    output reg  [DATA_W-1:0]        data_lines_out,
    output reg                      data_lines_oe_n,
    input  wire                     low_byte_strobe_in,
    output reg                      low_byte_strobe_out,
    output reg                      low_byte_strobe_oe_n,
    input  wire                     high_byte_strobe_in,
    output reg                      high_byte_strobe_out,
    output reg                      high_byte_strobe_oe_n,
    output wire                     arrWrValid,
    input  wire                     arrWrReady,
    output wire [2+ROW_W+COL_W-1:0] arrWrAddr,
    output wire [DATA_W-1:0]        arrWrData,
    output wire [DATA_W/8-1:0]      arrWrByteEn,
    output reg  [2+ROW_W+COL_W-1:0] arrRdAddr,
    input  wire [DATA_W-1:0]        arrRdData,
    output reg  [3:0]               bankActive,
    output reg                      refreshPulse,
    output reg  [3:0]               powerState,
    output reg  [ROW_W-1:0]         burst_mode_config,
    output reg  [ROW_W-1:0]         extModeReg
);

    localparam LANES  = DATA_W / 8;
    localparam ADDR_W = 2 + ROW_W + COL_W;
    localparam SYNC_W = 2 + 4 + 2 + ROW_W + LANES + LANES + DATA_W;
    localparam BUF_W  = ADDR_W + DATA_W + LANES;

    localparam ST_RUN     = 4'h1;
    localparam ST_PDN_PRE = 4'h2;
    localparam ST_PDN_ACT = 4'h4;
    localparam ST_SELF    = 4'h8;

    // Two-stage synchroniser for every pin
    reg  [SYNC_W-1:0] syncA;
    reg  [SYNC_W-1:0] syncB;
    reg               ckLast;
    reg  [LANES-1:0]  stbLast;
    wire [SYNC_W-1:0] pinBus = {memClk, clkEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeStrobe_n,
                                bank_select_bits, address, high_byte_strobe_in, low_byte_strobe_in,
                                high_byte_mask, low_byte_mask, data_lines_in};

    wire              ckNow   = syncB[SYNC_W-1];
    wire              ckeNow  = syncB[SYNC_W-2];
    wire [3:0]        cmdNow  = syncB[SYNC_W-3:SYNC_W-6];
    wire              chipSelect_nNow = cmdNow[3];
    wire [1:0]        bankNow = syncB[SYNC_W-7:SYNC_W-8];
    wire [ROW_W-1:0]  addrNow = syncB[SYNC_W-9:SYNC_W-8-ROW_W];
    wire [LANES-1:0]  stbNow  = syncB[DATA_W+2*LANES-1:DATA_W+LANES];
    wire [LANES-1:0]  maskNow = syncB[DATA_W+LANES-1:DATA_W];
    wire [DATA_W-1:0] dataNow = syncB[DATA_W-1:0];

    wire ckRise = ckNow & ~ckLast;
    wire ckFall = ~ckNow & ckLast;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA   <= {SYNC_W{1'b0}};
            syncB   <= {SYNC_W{1'b0}};
            ckLast  <= 1'b0;
            stbLast <= {LANES{1'b0}};
        end else begin
            syncA   <= pinBus;
            syncB   <= syncA;
            ckLast  <= ckNow;
            stbLast <= stbNow;
        end
    end

    // Mode decode
    reg  [3:0] burstLenCfg;
    reg  [2:0] latencyCfg;
    wire [2:0] blCode = burst_mode_config[`DDC_BL_MSB:`DDC_BL_LSB];
    wire [2:0] clCode = burst_mode_config[`DDC_CL_MSB:`DDC_CL_LSB];

    always @* begin
        case (blCode)
            `DDC_BL_CODE_4: burstLenCfg = `DDC_BL_4;
            `DDC_BL_CODE_8: burstLenCfg = `DDC_BL_8;
            default:        burstLenCfg = `DDC_BL_2;
        endcase
        case (clCode)
            `DDC_CL_CODE_4: latencyCfg = `DDC_CL_4;
            default:        latencyCfg = `DDC_CL_3;
        endcase
    end

    // Burst state
    reg              ckePrev;
    reg              burstRun;
    reg              burstIsRead;
    reg              burstInterleave;
    reg              burstAutoPre;
    reg [1:0]        burstBank;
    reg [ROW_W-1:0]  burstRow;
    reg [COL_W-1:0]  burstStart;
    reg [3:0]        burstIdx;
    reg [3:0]        burstLen;
    reg [2:0]        latCnt;
    reg [ROW_W-1:0]  rowAddr [0:3];

    function [COL_W-1:0] burstColumn;
        input [COL_W-1:0] start;
        input [3:0]       idx;
        input [3:0]       len;
        input             interleave;
        reg   [2:0]       span;
        reg   [2:0]       low;
        begin
            span = len[2:0] - 3'h1;
            low  = interleave ? (start[2:0] ^ idx[2:0]) : (start[2:0] + idx[2:0]);
            burstColumn = {start[COL_W-1:3], (start[2:0] & ~span) | (low & span)};
        end
    endfunction

    wire [3:0]       nextIdx = burstIdx + 4'h1;
    wire [COL_W-1:0] colCur  = burstColumn(burstStart, burstIdx, burstLen, burstInterleave);
    wire [COL_W-1:0] colNext = burstColumn(burstStart, nextIdx, burstLen, burstInterleave);
    wire             runEdge = ckePrev & (ckRise | ckFall);
    wire             writing = burstRun & ~burstIsRead;

    // Write capture per byte lane, each on its own strobe edges
    reg  [7:0]       laneData [0:LANES-1];
    reg  [LANES-1:0] laneMask;
    reg  [LANES-1:0] laneHit;
    wire             bufReady;
    wire             wordValid = writing & (&laneHit);
    wire             wordTaken = wordValid & bufReady;
    wire [DATA_W-1:0] wordData;

    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            wire stbEdge = writing & ckePrev & (stbNow[lane] ^ stbLast[lane]);
            assign wordData[lane*8+7:lane*8] = laneData[lane];
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    laneData[lane] <= 8'h00;
                    laneMask[lane] <= 1'b0;
                    laneHit[lane]  <= 1'b0;
                end else if (stbEdge) begin
                    laneData[lane] <= dataNow[lane*8+7:lane*8];
                    laneMask[lane] <= maskNow[lane];
                    laneHit[lane]  <= 1'b1;
                end else if (wordTaken || !writing) begin
                    laneHit[lane] <= 1'b0;
                end
            end
        end
    endgenerate

    ddc_pair_buffer #(
        .WIDTH(BUF_W)
    ) u_write_buffer (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .inValid  (wordValid),
        .inReady  (bufReady),
        .inData   ({burstBank, burstRow, colCur, wordData, ~laneMask}),
        .outValid (arrWrValid),
        .outReady (arrWrReady),
        .outData  ({arrWrAddr, arrWrData, arrWrByteEn})
    );

    // Main sequencer
    integer b;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ckePrev               <= 1'b0;
            burstRun              <= 1'b0;
            burstIsRead           <= 1'b0;
            burstInterleave       <= 1'b0;
            burstAutoPre          <= 1'b0;
            burstBank             <= 2'h0;
            burstRow              <= {ROW_W{1'b0}};
            burstStart            <= {COL_W{1'b0}};
            burstIdx              <= 4'h0;
            burstLen              <= `DDC_BL_2;
            latCnt                <= 3'h0;
            for (b = 0; b < 4; b = b + 1) begin
                rowAddr[b] <= {ROW_W{1'b0}};
            end
            bankActive            <= 4'h0;
            refreshPulse          <= 1'b0;
            powerState            <= ST_RUN;
            burst_mode_config     <= `DDC_MODE_RESET;
            extModeReg            <= `DDC_EXT_MODE_RESET;
            arrRdAddr             <= {ADDR_W{1'b0}};
            data_lines_out        <= {DATA_W{1'b0}};
            data_lines_oe_n       <= 1'b1;
            low_byte_strobe_out   <= 1'b0;
            low_byte_strobe_oe_n  <= 1'b1;
            high_byte_strobe_out  <= 1'b0;
            high_byte_strobe_oe_n <= 1'b1;
        end else begin
            refreshPulse <= 1'b0;

            // Read burst: latency, then a word on every edge
            if (runEdge && burstRun && burstIsRead) begin
                if (ckRise && latCnt != 3'h0) begin
                    latCnt <= latCnt - 3'h1;
                end
                if (ckRise && latCnt == 3'h2) begin
                    // Preamble: strobes driven low a clock ahead of data
                    low_byte_strobe_oe_n  <= 1'b0;
                    high_byte_strobe_oe_n <= 1'b0;
                    low_byte_strobe_out   <= 1'b0;
                    high_byte_strobe_out  <= 1'b0;
                end
                if (latCnt == 3'h0 || (ckRise && latCnt == 3'h1)) begin
                    if (burstIdx != burstLen) begin
                        data_lines_out        <= arrRdData;
                        data_lines_oe_n       <= 1'b0;
                        low_byte_strobe_out   <= ckRise;
                        high_byte_strobe_out  <= ckRise;
                        low_byte_strobe_oe_n  <= 1'b0;
                        high_byte_strobe_oe_n <= 1'b0;
                        burstIdx              <= nextIdx;
                        arrRdAddr             <= {burstBank, burstRow, colNext};
                    end else begin
                        burstRun              <= 1'b0;
                        data_lines_oe_n       <= 1'b1;
                        low_byte_strobe_oe_n  <= 1'b1;
                        high_byte_strobe_oe_n <= 1'b1;
                        if (burstAutoPre) begin
                            bankActive[burstBank] <= 1'b0;
                        end
                    end
                end
            end

            // Write burst ends when its last word enters the buffer
            if (wordTaken) begin
                burstIdx <= nextIdx;
                if (nextIdx == burstLen) begin
                    burstRun <= 1'b0;
                    if (burstAutoPre) begin
                        bankActive[burstBank] <= 1'b0;
                    end
                end
            end

            // Command decode on the memory clock rising edge
            if (ckRise) begin
                ckePrev <= ckeNow;
                if (ckePrev) begin
                    if (!ckeNow && (chipSelect_nNow || cmdNow == `DDC_CMD_NOP)) begin
                        powerState <= (|bankActive) ? ST_PDN_ACT : ST_PDN_PRE;
                    end else if (!chipSelect_nNow) begin
                        case (cmdNow)
                            `DDC_CMD_ROW_OPEN: begin
                                bankActive[bankNow] <= 1'b1;
                                rowAddr[bankNow]    <= addrNow;
                            end
                            `DDC_CMD_ROW_CLOSE: begin
                                if (addrNow[`DDC_AP_BIT]) begin
                                    bankActive <= 4'h0;
                                end else begin
                                    bankActive[bankNow] <= 1'b0;
                                end
                            end
                            `DDC_CMD_READ, `DDC_CMD_WRITE: begin
                                if (bankActive[bankNow]) begin
                                    burstRun        <= 1'b1;
                                    burstIsRead     <= (cmdNow == `DDC_CMD_READ);
                                    burstBank       <= bankNow;
                                    burstRow        <= rowAddr[bankNow];
                                    burstStart      <= addrNow[COL_W-1:0];
                                    burstAutoPre    <= addrNow[`DDC_AP_BIT];
                                    burstInterleave <= burst_mode_config[`DDC_BT_BIT];
                                    burstLen        <= burstLenCfg;
                                    burstIdx        <= 4'h0;
                                    latCnt          <= latencyCfg;
                                    arrRdAddr       <= {bankNow, rowAddr[bankNow], addrNow[COL_W-1:0]};
                                end
                            end
                            `DDC_CMD_MODE_LOAD: begin
                                if (ckeNow && bankActive == 4'h0) begin
                                    if (bankNow[`DDC_EXT_SEL_BIT]) begin
                                        extModeReg <= addrNow;
                                    end else begin
                                        burst_mode_config <= addrNow;
                                    end
                                end
                            end
                            `DDC_CMD_BURST_STOP: begin
                                if (burstRun && burstIsRead) begin
                                    burstRun              <= 1'b0;
                                    data_lines_oe_n       <= 1'b1;
                                    low_byte_strobe_oe_n  <= 1'b1;
                                    high_byte_strobe_oe_n <= 1'b1;
                                end
                            end
                            `DDC_CMD_REFRESH: begin
                                if (bankActive == 4'h0) begin
                                    if (ckeNow) begin
                                        refreshPulse <= 1'b1;
                                    end else begin
                                        powerState <= ST_SELF;
                                    end
                                end
                            end
                            default: begin
                                // No-operation
                            end
                        endcase
                    end
                end else if (ckeNow) begin
                    powerState <= ST_RUN;
                end
            end
        end
    end


endmodule // ddc_command_core

// File: verification/ddc_command_core_props.sv
// Port assertions for the command core
`timescale 1ns/1ps
module ddc_command_core_props (
    input wire        sys_clk,
    input wire        reset_n,
    input wire        data_lines_oe_n,
    input wire        low_byte_strobe_oe_n,
    input wire        high_byte_strobe_oe_n,
    input wire        arrWrValid,
    input wire        arrWrReady,
    input wire [22:0] arrWrAddr,
    input wire [15:0] arrWrData,
    input wire [1:0]  arrWrByteEn,
    input wire [3:0]  bankActive,
    input wire        refreshPulse,
    input wire [3:0]  powerState,
    input wire [11:0] burst_mode_config,
    input wire [11:0] extModeReg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_lane_strobes_pair: assert property (low_byte_strobe_oe_n == high_byte_strobe_oe_n)
        else $error("lane strobes enabled apart");
    a_read_preamble: assert property ($fell(data_lines_oe_n) |-> $past(low_byte_strobe_oe_n, 4) == 1'b0)
        else $error("read data without strobe preamble");
    a_refresh_single: assert property (refreshPulse |=> (!refreshPulse) [*6])
        else $error("refresh pulse too long");
    a_refresh_idle: assert property (refreshPulse |-> bankActive == 4'h0)
        else $error("refresh with open bank");
    a_power_onehot: assert property ($onehot(powerState))
        else $error("power state not one-hot");
    a_idle_power_down: assert property ((powerState[1] || powerState[3]) |-> bankActive == 4'h0)
        else $error("idle low-power mode with open bank");
    a_active_power_down: assert property (powerState[2] |-> bankActive != 4'h0)
        else $error("active power-down with no bank open");
    a_frozen_banks: assert property (!powerState[0] && $past(powerState[0]) == 1'b0 |-> $stable(bankActive))
        else $error("bank state moved while clock suspended");
    a_mode_load_idle: assert property (!$stable(burst_mode_config) || !$stable(extModeReg) |-> $past(bankActive) == 4'h0)
        else $error("mode register written with bank open");
    a_write_hold: assert property (arrWrValid && !arrWrReady |=> arrWrValid && $stable({arrWrAddr, arrWrData, arrWrByteEn}))
        else $error("write word dropped under stall");
    c_refresh: cover property (refreshPulse);
    c_self_refresh: cover property (powerState == 4'h8);
    c_write: cover property (arrWrValid && arrWrReady);
    c_read: cover property ($fell(data_lines_oe_n));
endmodule // ddc_command_core_props

// File: verification/ddc_ctrl_model.sv
// Behavioural memory controller driving the command core pins
`timescale 1ns/1ps
`include "ddc_defines.vh"
module ddc_ctrl_model (
    input  wire        sys_clk,
    output reg         memClk,
    output reg         clkEnable,
    output reg         chipSelect_n,
    output reg         rowStrobe_n,
    output reg         colStrobe_n,
    output reg         writeStrobe_n,
    output reg  [1:0]  bank_select_bits,
    output reg  [11:0] address,
    output reg         low_byte_mask,
    output reg         high_byte_mask,
    output wire [15:0] data_lines_in,
    input  wire [15:0] data_lines_out,
    input  wire        data_lines_oe_n,
    output wire        low_byte_strobe_in,
    input  wire        low_byte_strobe_out,
    input  wire        low_byte_strobe_oe_n,
    output wire        high_byte_strobe_in,
    input  wire        high_byte_strobe_out,
    input  wire        high_byte_strobe_oe_n
);
    reg        drv;
    reg        sCtl;
    reg [15:0] dCtl;
    // Released lines show the last driven value while drv is set, and its inverse while drv is clear
    assign data_lines_in = !data_lines_oe_n ? data_lines_out : (drv ? dCtl : ~dCtl);
    assign low_byte_strobe_in = !low_byte_strobe_oe_n ? low_byte_strobe_out : (drv ? sCtl : ~sCtl);
    assign high_byte_strobe_in = !high_byte_strobe_oe_n ? high_byte_strobe_out : (drv ? sCtl : ~sCtl);
    initial begin
        {chipSelect_n, rowStrobe_n, colStrobe_n, writeStrobe_n} = `DDC_CMD_NOP;
        {clkEnable, bank_select_bits, address, low_byte_mask, high_byte_mask} = {1'b1, 16'h0000};
        {drv, sCtl, dCtl} = 18'h0_0000;
        memClk = 1'b0;
        #13;
        forever #200 memClk = ~memClk;
    end
    // Pins set at the falling edge, valid around the next rise
    task cmd(input [3:0] c, input [1:0] b, input [11:0] a, input ce);
        begin
            @(negedge memClk);
            @(negedge sys_clk);
            {chipSelect_n, rowStrobe_n, colStrobe_n, writeStrobe_n, bank_select_bits, address, clkEnable} = {c, b, a, ce};
            @(negedge memClk);
            @(negedge sys_clk);
            {chipSelect_n, rowStrobe_n, colStrobe_n, writeStrobe_n, bank_select_bits, address} = {`DDC_CMD_NOP, ~b, ~a};
        end
    endtask
    // One word per half clock, strobe edge centred on the data
    task wword(input [15:0] d, input [1:0] m);
        begin
            {dCtl, high_byte_mask, low_byte_mask} = {d, m};
            repeat (2) @(negedge sys_clk);
            sCtl = ~sCtl;
            repeat (2) @(negedge sys_clk);
        end
    endtask
endmodule // ddc_ctrl_model

// File: verification/ddc_command_core_test.sv
// Self-checking bench for the command core
`timescale 1ns/1ps
`include "ddc_defines.vh"
module ddc_command_core_test;
    reg          sys_clk, reset_n, arrWrReady, hold, lastStb, il;
    reg   [1:0]  b, m;
    reg   [3:0]  bl;
    reg   [8:0]  col;
    reg   [11:0] row, mode;
    reg   [15:0] d, eRd;
    reg   [40:0] eWr;
    integer      i, j, num_errors, compares, cycles, refreshes, r0;
    logic [15:0] rdQ[$];
    logic [40:0] wrQ[$];
    wire         memClk, clkEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeStrobe_n, refreshPulse;
    wire         low_byte_mask, high_byte_mask, data_lines_oe_n, arrWrValid;
    wire         low_byte_strobe_in, low_byte_strobe_out, low_byte_strobe_oe_n;
    wire         high_byte_strobe_in, high_byte_strobe_out, high_byte_strobe_oe_n;
    wire  [1:0]  bank_select_bits, arrWrByteEn;
    wire  [3:0]  bankActive, powerState;
    wire  [11:0] address, burst_mode_config, extModeReg;
    wire  [15:0] data_lines_in, data_lines_out, arrWrData, arrRdData;
    wire  [22:0] arrWrAddr, arrRdAddr;
    function [15:0] rdv(input [22:0] a);
        rdv = a[15:0] ^ {9'h000, a[22:16]};
    endfunction
    function [8:0] bcol(input [8:0] c, input [3:0] k, input [3:0] n, input x);
        bcol = x ? c ^ k : (c & ~(n - 9'h001)) | ((c + k) & (n - 9'h001));
    endfunction
    assign arrRdData = rdv(arrRdAddr);
    ddc_command_core i_dut (.*);
    ddc_ctrl_model i_ctrl (.*);
    task chk(input logic [40:0] got, input logic [40:0] want);
        begin
            compares++;
            if (got !== want) begin
                num_errors++;
                $display("Error %0t: got %h expected %h", $time, got, want);
            end
        end
    endtask
    task settle;
        repeat (6) @(negedge sys_clk);
    endtask
    task pw(input [3:0] c, input [3:0] st);
        begin
            i_ctrl.cmd(c, 2'h0, 12'h000, 1'b0);
            settle;
            chk(powerState, st);
            i_ctrl.cmd(`DDC_CMD_NOP, 2'h0, 12'h000, 1'b1);
            settle;
            chk(powerState, 4'h1);
        end
    endtask
    task print_verdict;
        begin
            $display("Compares %0d, errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always #25 sys_clk = ~sys_clk;
    always @(negedge sys_clk) arrWrReady <= !hold && ($urandom % 3 != 0);
    // Each strobe change while driving marks one read word
    always @(negedge sys_clk) begin
        if (reset_n && !data_lines_oe_n && low_byte_strobe_out !== lastStb) begin
            eRd = rdQ.size() ? rdQ.pop_front() : ~data_lines_out;
            chk(data_lines_out, eRd);
        end
        lastStb <= low_byte_strobe_out;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (refreshPulse === 1'b1) refreshes++;
        if (reset_n && arrWrValid === 1'b1 && arrWrReady) begin
            eWr = wrQ.size() ? wrQ.pop_front() : {41{1'b1}};
            chk({arrWrAddr, arrWrData & {{8{eWr[1]}}, {8{eWr[0]}}}, arrWrByteEn}, eWr);
        end
        if (cycles == 30000) begin
            num_errors++;
            $display("Error %0t: timeout", $time);
            print_verdict;
        end
    end
    initial begin
        {sys_clk, reset_n, arrWrReady, hold, lastStb} = 5'h00;
        {num_errors, compares, cycles, refreshes} = 128'h0;
        r0 = $urandom(32'ha82b);
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
        chk({powerState, burst_mode_config, extModeReg, bankActive}, 32'h1000_0000);
        i_ctrl.cmd(`DDC_CMD_NOP, 2'h0, 12'h000, 1'b1);
        for (i = 0; i < 6; i++) begin
            bl = 4'h2 << (i % 3);
            il = (i > 2);
            b = 2'(i % 4);
            mode = {5'h00, 3'h3 + 3'(i % 2), il, 3'(i % 3 + 1)};
            i_ctrl.cmd(`DDC_CMD_MODE_LOAD, 2'h0, mode, 1'b1);
            repeat (2) i_ctrl.cmd(`DDC_CMD_NOP, 2'h0, 12'h000, 1'b1);
            chk(burst_mode_config, mode);
            row = 12'($urandom);
            col = 9'($urandom);
            i_ctrl.cmd(`DDC_CMD_ROW_OPEN, b, row, 1'b1);
            settle;
            chk(bankActive, 4'h1 << b);
            for (j = 0; j < bl; j++) rdQ.push_back(rdv({b, row, bcol(col, j[3:0], bl, il)}));
            i_ctrl.cmd(`DDC_CMD_READ, b, {3'h2, col}, 1'b1);
            repeat (10) @(negedge memClk);
            chk(bankActive, 4'h0);
        end
        i_ctrl.cmd(`DDC_CMD_MODE_LOAD, 2'h1, 12'h041, 1'b1);
        repeat (2) i_ctrl.cmd(`DDC_CMD_NOP, 2'h0, 12'h000, 1'b1);
        chk({extModeReg, burst_mode_config}, {12'h041, mode});
        i_ctrl.cmd(`DDC_CMD_ROW_OPEN, 2'h1, row, 1'b1);
        i_ctrl.cmd(`DDC_CMD_ROW_OPEN, 2'h2, row, 1'b1);
        i_ctrl.cmd(`DDC_CMD_ROW_CLOSE, 2'h1, 12'h000, 1'b1);
        i_ctrl.cmd(4'hb, 2'h0, 12'h000, 1'b1);
        i_ctrl.cmd(`DDC_CMD_MODE_LOAD, 2'h0, 12'h000, 1'b1);
        settle;
        chk({bankActive, burst_mode_config}, {4'h4, mode});
        pw(`DDC_CMD_NOP, 4'h4);
        i_ctrl.cmd(`DDC_CMD_ROW_CLOSE, 2'h0, 12'h400, 1'b1);
        pw(`DDC_CMD_NOP, 4'h2);
        pw(`DDC_CMD_REFRESH, 4'h8);
        r0 = refreshes;
        i_ctrl.cmd(`DDC_CMD_REFRESH, 2'h0, 12'h000, 1'b1);
        settle;
        chk(refreshes, r0 + 1);
        i_ctrl.cmd(`DDC_CMD_MODE_LOAD, 2'h0, 12'h032, 1'b1);
        repeat (2) i_ctrl.cmd(`DDC_CMD_NOP, 2'h0, 12'h000, 1'b1);
        i_ctrl.cmd(`DDC_CMD_ROW_OPEN, 2'h3, row, 1'b1);
        {i_ctrl.drv, i_ctrl.sCtl, hold} = 3'h5;
        i_ctrl.cmd(`DDC_CMD_WRITE, 2'h3, {3'h0, col}, 1'b1);
        for (j = 0; j < 4; j++) begin
            d = 16'($urandom);
            m = 2'($urandom);
            wrQ.push_back({2'h3, row, bcol(col, j[3:0], 4'h4, 1'b0), d & {{8{~m[1]}}, {8{~m[0]}}}, ~m});
            i_ctrl.wword(d, m);
            hold = (j < 1);
        end
        repeat (4) @(negedge memClk);
        {i_ctrl.drv, hold} = 2'h0;
        repeat (2) @(negedge memClk);
        chk(rdQ.size() + wrQ.size(), 0);
        print_verdict;
    end
endmodule // ddc_command_core_test
bind ddc_command_core ddc_command_core_props i_props (.*);
